//--- logic/amc_ctrl.sv
// converter control registers, result bytes and interrupt flags on the SFR bus
// Behaviour
// - upper mux nibble picks positive input: 0-5 analog, 6-7 neg ref, 8 common
// - lower mux nibble picks negative input with the same codes
// - temperature sensor connects only when the mux register is all ones
// - aux interrupt enable gates aux interrupt and is clear after reset
// - aux flag holds until software clears it; still set means interrupt again
// - software writing one to aux flag raises aux interrupt when enabled
// - watchdog flag in bit 3 holds until cleared; software set requests interrupt
// - watchdog interrupt only while watchdog reset action is disabled
// - reading the low result byte clears the converter interrupt request
// - result shown as low, middle, high byte; 16-bit variant top in middle
// - 16-bit variant high byte is sign fill bipolar, zero otherwise
// - bit 6 of front control turns on open input detect currents
// - bit 5 powers internal reference, set after reset
// - bit 4 picks reference level, one is high level and reset value
// - bit 3 enables input buffer, clear after reset
// - three-bit gain code selects gain one to 128 in powers of two
// - summation error bit sets on invalid sum, clears only by writing zero
// - polarity bit: zero bipolar, one unipolar, for result and summation
// - bipolar two's complement; unipolar zero to all ones, negative clamps zero
// - two-bit settling field picks auto, fast, sinc2 or sinc3 filter
// - writing calibration field starts that calibration; top two codes reserved
// - calibration field always reads back as zero
`timescale 1ns/1ps
`default_nettype none
module amc_ctrl
	import amc_pkg::*;
#(
	parameter int RESULT_BITS = 24
)(
	input  wire logic        ref_clk,          // system clock, 200 MHz
	input  wire logic        rstn,             // async reset, active low
	input  wire logic [7:0]  sfr_addr,         // SFR address
	input  wire logic        sfr_wr,           // write strobe
	input  wire logic        sfr_rd,           // read strobe
	input  wire logic [7:0]  sfr_wdata,        // write data
	output logic      [7:0]  sfr_rdata,        // read data, one cycle later
	input  wire logic        conv_done,        // conversion ready pulse
	input  wire logic [23:0] conv_data,        // signed filter output
	input  wire logic        sum_invalid,      // summation overflow pulse
	input  wire logic        aux_event,        // aux source event pulse
	input  wire logic        wdt_event,        // watchdog timeout pulse
	input  wire logic        wdt_irq_en,       // watchdog interrupt enable
	input  wire logic        wdt_reset_on,     // watchdog reset action enabled
	output logic      [7:0]  pos_select,       // positive input switches
	output logic      [7:0]  neg_select,       // negative input switches
	output logic             temp_sensor_on,   // temperature sensor routed
	output logic             open_input_detect,      // burnout currents on
	output logic             internal_reference_on,  // reference powered
	output logic             reference_level_high,   // high reference level
	output logic             input_buffer_on,        // input buffer on
	output logic      [7:0]  gain_factor,      // amplifier gain, 1 to 128
	output logic             result_coding_select,   // 1 unipolar
	output amc_filter_e      filter_settling_select, // digital filter
	output logic             cal_start,        // calibration start pulse
	output amc_cal_e         calibration_command,    // calibration kind
	output logic             adc_irq_req,      // converter interrupt request
	output logic             aux_irq,          // aux interrupt request
	output logic             wdt_irq           // watchdog interrupt request
);
	localparam int RB = RESULT_BITS;

	logic [7:0]  mux_reg;
	logic [7:0]  front_reg;
	logic        sum_err_reg;
	logic        pol_reg;
	logic [1:0]  sm_reg;
	logic        aux_en_reg;
	logic        aux_flag_reg;
	logic        wdt_flag_reg;
	logic [23:0] result_reg;
	logic [23:0] result_next;
	logic [23:0] coded;
	logic        adc_irq_reg;
	logic [7:0]  gain_reg;
	logic [7:0]  rdata_next;
	logic        temp_reg;
	logic        cal_start_reg;
	amc_cal_e    cal_cmd_reg;

	logic wr_mux;
	logic wr_irq;
	logic wr_front;
	logic wr_coding;
	logic rd_low;

	assign wr_mux    = sfr_wr && sfr_addr == ADDR_MUX;
	assign wr_irq    = sfr_wr && sfr_addr == ADDR_IRQ;
	assign wr_front  = sfr_wr && sfr_addr == ADDR_FRONT;
	assign wr_coding = sfr_wr && sfr_addr == ADDR_CODING;
	assign rd_low    = sfr_rd && sfr_addr == ADDR_RES_L;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			mux_reg <= RST_MUX;
		else if (wr_mux)
			mux_reg <= sfr_wdata;
	end

	// both nibbles blocked while the sensor owns the converter
	amc_chan_decode u_pos (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.code    (mux_reg[7:4]),
		.blocked (mux_reg == MUX_TEMP),
		.rst_sel (8'h01),
		.sel     (pos_select)
	);

	amc_chan_decode u_neg (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.code    (mux_reg[3:0]),
		.blocked (mux_reg == MUX_TEMP),
		.rst_sel (8'h02),
		.sel     (neg_select)
	);

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			temp_reg <= 1'b0;
		else
			temp_reg <= mux_reg == MUX_TEMP;
	end
	assign temp_sensor_on = temp_reg;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			front_reg <= RST_FRONT;
		else if (wr_front)
			front_reg <= {1'b0, sfr_wdata[6:0]};
	end
	assign open_input_detect     = front_reg[FRONT_BOD];
	assign internal_reference_on = front_reg[FRONT_VREF];
	assign reference_level_high  = front_reg[FRONT_REFERENCE_LEVEL_HIGH];
	assign input_buffer_on       = front_reg[FRONT_BUF];

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			gain_reg <= 8'h01;
		else
			gain_reg <= 8'h01 << front_reg[FRONT_GAIN +: 3];
	end
	assign gain_factor = gain_reg;

	// hardware set beats a software clear in the same cycle
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			sum_err_reg <= RST_CODING[CODING_SUMERR];
		else if (sum_invalid)
			sum_err_reg <= 1'b1;
		else if (wr_coding && !sfr_wdata[CODING_SUMERR])
			sum_err_reg <= 1'b0;
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pol_reg <= RST_CODING[CODING_POL];
			sm_reg  <= RST_CODING[CODING_SM +: 2];
		end else if (wr_coding) begin
			pol_reg <= sfr_wdata[CODING_POL];
			sm_reg  <= sfr_wdata[CODING_SM +: 2];
		end
	end
	assign result_coding_select   = pol_reg;
	assign filter_settling_select = amc_filter_e'(sm_reg);

	// calibration field is write-only: it launches, it is never stored for reads
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			cal_start_reg <= 1'b0;
			cal_cmd_reg   <= AMC_CAL_NONE;
		end else begin
			cal_start_reg <= 1'b0;
			if (wr_coding && sfr_wdata[CODING_CAL +: 3] != 3'h0
			    && sfr_wdata[CODING_CAL +: 3] < 3'h6) begin
				cal_start_reg <= 1'b1;
				cal_cmd_reg   <= amc_cal_e'(sfr_wdata[CODING_CAL +: 3]);
			end
		end
	end
	assign cal_start           = cal_start_reg;
	assign calibration_command = cal_cmd_reg;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			aux_en_reg   <= RST_IRQ[IRQ_AUX_EN];
			aux_flag_reg <= RST_IRQ[IRQ_AUX_FLG];
		end else begin
			if (wr_irq)
				aux_en_reg <= sfr_wdata[IRQ_AUX_EN];
			if (aux_event)
				aux_flag_reg <= 1'b1;
			else if (wr_irq)
				aux_flag_reg <= sfr_wdata[IRQ_AUX_FLG];
		end
	end
	assign aux_irq = aux_en_reg && aux_flag_reg;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			wdt_flag_reg <= RST_IRQ[IRQ_WDT_FLG];
		else if (wdt_event)
			wdt_flag_reg <= 1'b1;
		else if (wr_irq)
			wdt_flag_reg <= sfr_wdata[IRQ_WDT_FLG];
	end
	// path exists only when the watchdog is not set to reset the chip
	assign wdt_irq = wdt_flag_reg && wdt_irq_en && !wdt_reset_on;

	// unipolar doubles the positive half so full scale reaches all ones
	always_comb begin
		if (!pol_reg)
			coded = conv_data;
		else if (conv_data[23])
			coded = 24'h000000;
		else
			coded = {conv_data[22:0], conv_data[22]};
		if (RB == 16) begin
			result_next[15:0]  = coded[23:8];
			result_next[23:16] = (!pol_reg && coded[23]) ? 8'hFF : 8'h00;
		end else begin
			result_next = coded;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			result_reg <= {RST_RES, RST_RES, RST_RES};
		else if (conv_done)
			result_reg <= result_next;
	end

	// a new sample in the read cycle keeps the request pending
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			adc_irq_reg <= 1'b0;
		else if (conv_done)
			adc_irq_reg <= 1'b1;
		else if (rd_low)
			adc_irq_reg <= 1'b0;
	end
	assign adc_irq_req = adc_irq_reg;

	always_comb begin
		case (sfr_addr)
			ADDR_MUX:    rdata_next = mux_reg;
			ADDR_IRQ:    rdata_next = IRQ_FIXED | {2'b00, aux_en_reg, aux_flag_reg,
			                                      wdt_flag_reg, 3'b000};
			ADDR_RES_L:  rdata_next = result_reg[7:0];
			ADDR_RES_M:  rdata_next = result_reg[15:8];
			ADDR_RES_H:  rdata_next = result_reg[23:16];
			ADDR_FRONT:  rdata_next = front_reg;
			ADDR_CODING: rdata_next = {sum_err_reg, pol_reg, sm_reg, 4'h0};
			default:     rdata_next = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			sfr_rdata <= 8'h00;
		else if (sfr_rd)
			sfr_rdata <= rdata_next;
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);

	sequence s_sample;
		conv_done;
	endsequence

	sequence s_low_read;
		rd_low && !conv_done;
	endsequence

	sequence s_aux_set_enabled;
		wr_irq && sfr_wdata[IRQ_AUX_EN] && sfr_wdata[IRQ_AUX_FLG];
	endsequence

	temp_route_a: assert property (1'b1 |=> temp_sensor_on == ($past(mux_reg) == MUX_TEMP))
		else $error("temperature sensor routing wrong");

	pos_common_a: assert property ((mux_reg[7:4] == CODE_COMMON) |=> pos_select == 8'h80)
		else $error("positive common input not selected");

	neg_ref_a: assert property ((mux_reg[3:0] == CODE_NEG_REF_B) |=> neg_select == 8'h40)
		else $error("negative reference input not selected");

	aux_gate_a: assert property (!aux_en_reg |-> !aux_irq)
		else $error("aux interrupt raised while disabled");

	aux_hold_a: assert property (aux_flag_reg && !wr_irq |=> aux_flag_reg)
		else $error("aux flag dropped without software clear");

	aux_soft_set_a: assert property (s_aux_set_enabled |=> aux_irq)
		else $error("software aux set did not interrupt");

	wdt_block_a: assert property (wdt_reset_on |-> !wdt_irq)
		else $error("watchdog interrupt while reset action on");

	wdt_hold_a: assert property (wdt_event |=> wdt_flag_reg [*1] ##0
		(wdt_irq == (wdt_irq_en && !wdt_reset_on)))
		else $error("watchdog flag not held");

	low_read_clear_a: assert property (s_low_read |=> !adc_irq_req)
		else $error("low byte read did not clear request");

	sample_raise_a: assert property (s_sample |=> adc_irq_req ##0
		result_reg == $past(result_next))
		else $error("result bytes not loaded together");

	sign_fill_a: assert property ((RB == 16) && conv_done && !pol_reg && conv_data[23]
		|=> result_reg[23:16] == 8'hFF)
		else $error("high byte not sign filled");

	clamp_a: assert property (conv_done && pol_reg && conv_data[23] |=> result_reg == 24'h0)
		else $error("unipolar negative not clamped");

	sum_err_a: assert property (sum_invalid |=> sum_err_reg)
		else $error("summation error not set");

	sum_hold_a: assert property (sum_err_reg && !(wr_coding && !sfr_wdata[CODING_SUMERR])
		|=> sum_err_reg)
		else $error("summation error not sticky");

	gain_decode_a: assert property (1'b1 |=>
		gain_factor == (8'h01 << $past(front_reg[FRONT_GAIN +: 3])))
		else $error("gain code decoded wrong");

	cal_read_a: assert property (sfr_rd && sfr_addr == ADDR_CODING
		|=> sfr_rdata[2:0] == 3'h0)
		else $error("calibration field read not zero");

	cal_launch_a: assert property (wr_coding && sfr_wdata[2:0] == 3'h4
		|=> cal_start && calibration_command == AMC_CAL_SYS_OFS)
		else $error("calibration not started");

	cal_reserved_a: assert property (wr_coding && (sfr_wdata[2:0] == 3'h0
		|| sfr_wdata[2:0] > 3'h5) |=> !cal_start)
		else $error("calibration started by idle or reserved code");
endmodule
`default_nettype wire

//--- logic/amc_pkg.sv
// register map, field layout and reset values of the converter control block
package amc_pkg;
	localparam logic [7:0] ADDR_MUX    = 8'hD7;
	localparam logic [7:0] ADDR_IRQ    = 8'hD8;
	localparam logic [7:0] ADDR_RES_L  = 8'hD9;
	localparam logic [7:0] ADDR_RES_M  = 8'hDA;
	localparam logic [7:0] ADDR_RES_H  = 8'hDB;
	localparam logic [7:0] ADDR_FRONT  = 8'hDC;
	localparam logic [7:0] ADDR_CODING = 8'hDD;

	localparam logic [7:0] RST_MUX    = 8'h01;
	localparam logic [7:0] RST_IRQ    = 8'h40;
	localparam logic [7:0] RST_RES    = 8'h00;
	localparam logic [7:0] RST_FRONT  = 8'h30;
	localparam logic [7:0] RST_CODING = 8'h00;

	// fixed bits of the interrupt register: bit 6 reads one, 7 and 2..0 zero
	localparam logic [7:0] IRQ_FIXED   = 8'h40;
	localparam int         IRQ_AUX_EN  = 5;
	localparam int         IRQ_AUX_FLG = 4;
	localparam int         IRQ_WDT_FLG = 3;

	localparam int FRONT_BOD   = 6;
	localparam int FRONT_VREF  = 5;
	localparam int FRONT_REFERENCE_LEVEL_HIGH = 4;
	localparam int FRONT_BUF   = 3;
	localparam int FRONT_GAIN  = 0;

	localparam int CODING_SUMERR = 7;
	localparam int CODING_POL    = 6;
	localparam int CODING_SM     = 4;
	localparam int CODING_CAL    = 0;

	localparam logic [3:0] CODE_NEG_REF_A = 4'h6;
	localparam logic [3:0] CODE_NEG_REF_B = 4'h7;
	localparam logic [3:0] CODE_COMMON    = 4'h8;
	localparam logic [7:0] MUX_TEMP       = 8'hFF;
	localparam int         SEL_NEG_REF    = 6;
	localparam int         SEL_COMMON     = 7;

	typedef enum logic [1:0] {
		AMC_FILT_AUTO,
		AMC_FILT_FAST,
		AMC_FILT_SINC2,
		AMC_FILT_SINC3
	} amc_filter_e;

	typedef enum logic [2:0] {
		AMC_CAL_NONE,
		AMC_CAL_SELF_BOTH,
		AMC_CAL_SELF_OFS,
		AMC_CAL_SELF_GAIN,
		AMC_CAL_SYS_OFS,
		AMC_CAL_SYS_GAIN,
		AMC_CAL_RSVD6,
		AMC_CAL_RSVD7
	} amc_cal_e;
endpackage

//--- logic/amc_chan_decode.sv
// one multiplexer nibble turned into a registered one-hot input switch set
`timescale 1ns/1ps
`default_nettype none
module amc_chan_decode
	import amc_pkg::*;
(
	input  wire logic       ref_clk, // system clock
	input  wire logic       rstn,    // async reset, active low
	input  wire logic [3:0] code,    // selection nibble
	input  wire logic       blocked, // temperature sensor owns the input
	input  wire logic [7:0] rst_sel, // switch set input, unused; reset clears sel
	output logic      [7:0] sel      // 0-5 analog, 6 neg reference, 7 common
);
	logic [7:0] sel_next;

	always_comb begin
		sel_next = 8'h00;
		if (!blocked) begin
			if (code < 4'h6)
				sel_next[code[2:0]] = 1'b1;
			else if (code == CODE_NEG_REF_A || code == CODE_NEG_REF_B)
				sel_next[SEL_NEG_REF] = 1'b1;
			else if (code == CODE_COMMON)
				sel_next[SEL_COMMON] = 1'b1;
		end
	end

	// reset clears every switch to zero; the rst_sel input is never used
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			sel <= 8'h00;
		else
			sel <= sel_next;
	end
endmodule
`default_nettype wire

//--- testbench/adc_mux_gain_cal_ctrl_tb_top.sv
// self-checking bench for the converter control registers, 24-bit and 16-bit results
`timescale 1ns/1ps
`default_nettype none
module adc_mux_gain_cal_ctrl_tb_top;
	import amc_pkg::*;
	logic        ref_clk, rstn, sfr_wr, sfr_rd, conv_done, sum_invalid, aux_event, wdt_event;
	logic        wdt_irq_en, wdt_reset_on, temp_sensor_on, open_input_detect, input_buffer_on;
	logic        internal_reference_on, reference_level_high, result_coding_select;
	logic        cal_start, adc_irq_req, aux_irq, wdt_irq;
	logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, rd16, pos_select, neg_select, gain_factor;
	logic [7:0]  got, got16, v;
	logic [23:0] conv_data;
	amc_filter_e filter_settling_select;
	amc_cal_e    calibration_command;
	int          fails, checks_done;

	amc_ctrl #(.RESULT_BITS(24)) DUT (.ref_clk, .rstn, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
		.sfr_rdata, .conv_done, .conv_data, .sum_invalid, .aux_event, .wdt_event, .wdt_irq_en,
		.wdt_reset_on, .pos_select, .neg_select, .temp_sensor_on, .open_input_detect,
		.internal_reference_on, .reference_level_high, .input_buffer_on, .gain_factor,
		.result_coding_select, .filter_settling_select, .cal_start, .calibration_command,
		.adc_irq_req, .aux_irq, .wdt_irq);
	// narrow variant shares every input, only its read data is watched
	amc_ctrl #(.RESULT_BITS(16)) DUT16 (.ref_clk, .rstn, .sfr_addr, .sfr_wr, .sfr_rd,
		.sfr_wdata, .sfr_rdata(rd16), .conv_done, .conv_data, .sum_invalid, .aux_event,
		.wdt_event, .wdt_irq_en, .wdt_reset_on, .pos_select(), .neg_select(),
		.temp_sensor_on(), .open_input_detect(), .internal_reference_on(),
		.reference_level_high(), .input_buffer_on(), .gain_factor(),
		.result_coding_select(), .filter_settling_select(), .cal_start(),
		.calibration_command(), .adc_irq_req(), .aux_irq(), .wdt_irq());

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk8(input logic [7:0] g, input logic [7:0] e, input string m);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("BAD %0t %s got %h expected %h", $time, m, g, e);
		end
	endtask

	task automatic chk1(input logic g, input logic e, input string m);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("BAD %0t %s got %b expected %b", $time, m, g, e);
		end
	endtask

	// strobes rise one falling edge after entry, so back-to-back calls never overlap
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge ref_clk);
		sfr_wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(negedge ref_clk);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge ref_clk);
		sfr_rd = 1'b0;
		got = sfr_rdata;
		got16 = rd16;
	endtask

	task automatic conv(input logic [23:0] d);
		@(negedge ref_clk);
		conv_data = d;
		conv_done = 1'b1;
		@(negedge ref_clk);
		conv_done = 1'b0;
	endtask

	task automatic pulse_ev(input logic [2:0] m);
		@(negedge ref_clk);
		{sum_invalid, aux_event, wdt_event} = m;
		@(negedge ref_clk);
		{sum_invalid, aux_event, wdt_event} = 3'b000;
	endtask

	task automatic res(input logic [23:0] e, input logic [23:0] e16);
		rd(ADDR_RES_L);
		chk8(got, e[7:0], "low byte");
		chk8(got16, e16[7:0], "low byte narrow");
		rd(ADDR_RES_M);
		chk8(got, e[15:8], "middle byte");
		chk8(got16, e16[15:8], "middle byte narrow");
		rd(ADDR_RES_H);
		chk8(got, e[23:16], "high byte");
		chk8(got16, e16[23:16], "high byte narrow");
	endtask

	function automatic logic [7:0] sel_of(input logic [3:0] c);
		if (c < 4'h6) return 8'h01 << c;
		if (c < 4'h8) return 8'h40;
		if (c == 4'h8) return 8'h80;
		return 8'h00;
	endfunction

	initial begin
		#50000;
		fails++;
		report_and_stop();
	end

	initial begin
		static logic [7:0] rst_val [7] = '{RST_MUX, RST_IRQ, RST_RES, RST_RES, RST_RES,
			RST_FRONT, RST_CODING};
		logic [3:0] n;
		fails = 0;
		checks_done = 0;
		{rstn, sfr_wr, sfr_rd, conv_done, sum_invalid, aux_event, wdt_event} = 7'h00;
		{wdt_irq_en, wdt_reset_on} = 2'b10;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		conv_data = 24'h000000;
		repeat (12) @(negedge ref_clk);
		rstn = 1'b1;
		for (int i = 0; i < 7; i++) begin
			rd(ADDR_MUX + 8'(i));
			chk8(got, rst_val[i], "reset value");
		end
		rd(8'hD0);
		chk8(got, 8'h00, "unmapped read");
		chk8(pos_select, 8'h01, "pos after reset");
		chk8(neg_select, 8'h02, "neg after reset");
		chk8(gain_factor, 8'h01, "gain after reset");
		chk1(internal_reference_on, 1'b1, "ref on after reset");
		chk1(reference_level_high, 1'b1, "ref high after reset");
		chk1(input_buffer_on, 1'b0, "buffer after reset");
		// mux codes 0..8 on both nibbles, then the sensor code and a near miss
		for (int c = 0; c < 9; c++) begin
			n = 4'((c + 3) % 9);
			wr(ADDR_MUX, {4'(c), n});
			@(negedge ref_clk);
			chk8(pos_select, sel_of(4'(c)), "pos select");
			chk8(neg_select, sel_of(n), "neg select");
			chk1(temp_sensor_on, 1'b0, "sensor off");
		end
		wr(ADDR_MUX, MUX_TEMP);
		@(negedge ref_clk);
		chk1(temp_sensor_on, 1'b1, "sensor on");
		chk8(pos_select | neg_select, 8'h00, "switches open for sensor");
		wr(ADDR_MUX, 8'hF0);
		@(negedge ref_clk);
		chk1(temp_sensor_on, 1'b0, "sensor needs both nibbles");
		chk8(neg_select, 8'h01, "neg with upper all ones");
		// front control: alternate bit patterns over every gain code, bit 7 unused
		for (int g = 0; g < 8; g++) begin
			v = (g % 2 == 1) ? (8'hB0 | 8'(g)) : (8'h48 | 8'(g));
			wr(ADDR_FRONT, v);
			chk1(open_input_detect, v[6], "burnout");
			chk1(internal_reference_on, v[5], "ref power");
			chk1(reference_level_high, v[4], "ref level");
			chk1(input_buffer_on, v[3], "buffer");
			@(negedge ref_clk);
			chk8(gain_factor, 8'h01 << g, "gain");
			rd(ADDR_FRONT);
			chk8(got, v & 8'h7F, "front readback");
		end
		// every calibration code, filter code and both codings
		for (int c = 0; c < 8; c++) begin
			v = {1'b0, 1'(c >> 2), 2'(c), 1'b0, 3'(c)};
			wr(ADDR_CODING, v);
			chk1(cal_start, c >= 1 && c <= 5, "cal start");
			if (c >= 1 && c <= 5) chk8({5'h00, calibration_command}, 8'(c), "cal kind");
			chk1(result_coding_select, v[6], "coding");
			chk8({6'h00, filter_settling_select}, 8'(c % 4), "filter");
			@(negedge ref_clk);
			chk1(cal_start, 1'b0, "cal start one cycle");
			rd(ADDR_CODING);
			chk8(got, v & 8'h70, "cal field reads zero");
		end
		pulse_ev(3'b100);
		rd(ADDR_CODING);
		chk8(got, 8'hF0, "sum error set");
		wr(ADDR_CODING, 8'h80);
		rd(ADDR_CODING);
		chk8(got, 8'h80, "sum error kept on one");
		wr(ADDR_CODING, 8'h00);
		rd(ADDR_CODING);
		chk8(got, 8'h00, "sum error cleared by zero");
		// aux and watchdog flags
		wr(ADDR_IRQ, 8'h10);
		chk1(aux_irq, 1'b0, "aux gated off");
		wr(ADDR_IRQ, 8'h30);
		chk1(aux_irq, 1'b1, "aux by software");
		wr(ADDR_IRQ, 8'h20);
		chk1(aux_irq, 1'b0, "aux cleared");
		pulse_ev(3'b010);
		repeat (4) @(negedge ref_clk);
		chk1(aux_irq, 1'b1, "aux flag holds");
		rd(ADDR_IRQ);
		chk8(got, 8'h70, "irq readback");
		wr(ADDR_IRQ, 8'hFF);
		rd(ADDR_IRQ);
		chk8(got, 8'h78, "irq fixed bits");
		chk1(wdt_irq, 1'b1, "watchdog by software");
		wdt_reset_on = 1'b1;
		#1 chk1(wdt_irq, 1'b0, "watchdog blocked by reset action");
		@(negedge ref_clk);
		wdt_reset_on = 1'b0;
		wr(ADDR_IRQ, 8'h00);
		chk1(wdt_irq, 1'b0, "watchdog cleared");
		pulse_ev(3'b001);
		repeat (3) @(negedge ref_clk);
		chk1(wdt_irq, 1'b1, "watchdog event held");
		wdt_irq_en = 1'b0;
		#1 chk1(wdt_irq, 1'b0, "watchdog gated by enable");
		@(negedge ref_clk);
		wdt_irq_en = 1'b1;
		#1 chk1(wdt_irq, 1'b1, "watchdog flag still set");
		@(negedge ref_clk);
		wr(ADDR_IRQ, 8'h00);
		// results, bipolar then unipolar, 24-bit and narrow side by side
		conv(24'h812345);
		chk1(adc_irq_req, 1'b1, "conversion request");
		wr(ADDR_RES_L, 8'h55);
		res(24'h812345, 24'hFF8123);
		chk1(adc_irq_req, 1'b0, "low read clears request");
		conv(24'h123456);
		res(24'h123456, 24'h001234);
		wr(ADDR_CODING, 8'h40);
		conv(24'hF00000);
		res(24'h000000, 24'h000000);
		conv(24'h400001);
		res(24'h800003, 24'h008000);
		conv(24'h7FFFFF);
		res(24'hFFFFFF, 24'h00FFFF);
		conv(24'h210800);
		rd(ADDR_RES_L);
		conv(24'h302A00);
		res(24'h605400, 24'h006054);
		report_and_stop();
	end
endmodule
`default_nettype wire
